// ===== rtl/bcd_digit.v
// Purpose: one bcd digit that counts up to a limit and wraps to zero
// Assumes: load and increment come from the same clock domain
// Notes: no reset on the value, the time starts unknown
`timescale 1ns/1ps

module bcd_digit #(
	parameter W     = 4,          // digit width
	parameter [W-1:0] LIMIT = 9   // highest legal value
) (
	input  wire         pclk,
	input  wire         ce,
	input  wire         load,
	input  wire [W-1:0] load_val,
	input  wire         inc,
	input  wire [W-1:0] wrap_at,
	output wire [W-1:0] value,
	output wire         carry
);

	reg [W-1:0] digit_q;          // held digit

	// carry out when incrementing at the current wrap value
	assign carry = inc && (digit_q == wrap_at);
	assign value = digit_q;

	// ----------------------------------------------------------------
	// digit register: a load from software beats a tick
	// ----------------------------------------------------------------
	always @(posedge pclk)
	begin
		if (ce)
		begin
			if (load)
				// out-of-range writes are clamped so the digit stays legal
				digit_q <= (load_val > LIMIT) ? LIMIT : load_val;
			else if (carry)
				digit_q <= {W{1'b0}};
			else if (inc)
				digit_q <= digit_q + {{(W-1){1'b0}}, 1'b1};
		end
	end

endmodule // bcd_digit

// ===== rtl/rtc_time_value_window.v
// Purpose: apb slave giving a pointer-selected view of the running time
// Assumes: one clock pclk at 40 MHz, ce freezes everything
// Notes: the slave answers with zero wait states; pslverr on unmapped
`timescale 1ns/1ps
`include "rtc_window_map.vh"

module rtc_time_value_window #(
	parameter [31:0] TICK_CYCLES = `TICK_CYCLES  // cycles per one-second tick
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg         second_tick
);

	// ----------------------------------------------------------------
	// control state
	// ----------------------------------------------------------------
	reg [1:0]  value_view_pointer_q;   // selects the view
	reg        clock_write_unlock_q;   // allows weekday/hours writes
	reg        run_q;                  // clock runs when set
	reg [31:0] tick_cnt_q;             // prescaler to one second

	// access decode
	wire setup    = psel && !penable;
	wire wr_now   = psel && penable && pwrite && pready;
	wire hit_ctrl = (paddr == `CTRL_ADDR);
	wire hit_val  = (paddr == `VALUE_ADDR);
	// low byte lanes carry the 16-bit value
	wire lo_lane  = pstrb[0];
	wire hi_lane  = pstrb[1];

	wire view_ms  = (value_view_pointer_q == `PTR_MIN_SEC);
	wire view_wh  = (value_view_pointer_q == `PTR_WEEKDAY_DIGIT_HOUR);
	wire wr_val   = wr_now && hit_val;
	wire wr_ms    = wr_val && view_ms;
	wire wr_wh    = wr_val && view_wh && clock_write_unlock_q;

	// ----------------------------------------------------------------
	// one-second prescaler
	// ----------------------------------------------------------------
	wire tick = run_q && (tick_cnt_q == TICK_CYCLES - 32'h0000_0001);

	// counts cycles while running; restarts when stopped
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt_q <= 32'h0000_0000;
		else if (ce)
		begin
			if (!run_q || tick)
				tick_cnt_q <= 32'h0000_0000;
			else
				tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// digit chain
	// ----------------------------------------------------------------
	wire [3:0] sec_one;
	wire [2:0] sec_ten;
	wire [3:0] min_one;
	wire [2:0] min_ten;
	wire [3:0] hr_one;
	wire [1:0] hr_ten;
	wire [2:0] weekday_digit;
	wire       c_s1, c_s10, c_m1, c_m10, c_h1, c_h10;

	// hours wrap at 23, ones digit wraps at 3 when tens is 2
	wire        day_end  = (hr_ten == 2'h2) && (hr_one == 4'h3) && c_m10;
	wire [3:0]  hr1_wrap = (hr_ten == 2'h2) ? 4'h3 : 4'h9;

	bcd_digit #(.W(4), .LIMIT(4'h9)) u_sec_one (
		.pclk(pclk), .ce(ce),
		.load(wr_ms && lo_lane),
		.load_val(pwdata[`SEC_ONE_MSB:`SEC_ONE_LSB]),
		.inc(tick), .wrap_at(4'h9),
		.value(sec_one), .carry(c_s1)
	);
	bcd_digit #(.W(3), .LIMIT(3'h5)) u_sec_ten (
		.pclk(pclk), .ce(ce),
		.load(wr_ms && lo_lane),
		.load_val(pwdata[`SEC_TEN_MSB:`SEC_TEN_LSB]),
		.inc(c_s1), .wrap_at(3'h5),
		.value(sec_ten), .carry(c_s10)
	);
	bcd_digit #(.W(4), .LIMIT(4'h9)) u_min_one (
		.pclk(pclk), .ce(ce),
		.load(wr_ms && hi_lane),
		.load_val(pwdata[`MIN_ONE_MSB:`MIN_ONE_LSB]),
		.inc(c_s10), .wrap_at(4'h9),
		.value(min_one), .carry(c_m1)
	);
	bcd_digit #(.W(3), .LIMIT(3'h5)) u_min_ten (
		.pclk(pclk), .ce(ce),
		.load(wr_ms && hi_lane),
		.load_val(pwdata[`MIN_TEN_MSB:`MIN_TEN_LSB]),
		.inc(c_m1), .wrap_at(3'h5),
		.value(min_ten), .carry(c_m10)
	);
	// hour ones, 0-9; carry at 9 or at 23
	bcd_digit #(.W(4), .LIMIT(4'h9)) u_hr_one (
		.pclk(pclk), .ce(ce),
		.load(wr_wh && lo_lane),
		.load_val(pwdata[`HR_ONE_MSB:`HR_ONE_LSB]),
		.inc(c_m10), .wrap_at(hr1_wrap),
		.value(hr_one), .carry(c_h1)
	);
	bcd_digit #(.W(2), .LIMIT(2'h2)) u_hr_ten (
		.pclk(pclk), .ce(ce),
		.load(wr_wh && lo_lane),
		.load_val(pwdata[`HR_TEN_MSB:`HR_TEN_LSB]),
		.inc(c_h1), .wrap_at(2'h2),
		.value(hr_ten), .carry(c_h10)
	);
	bcd_digit #(.W(3), .LIMIT(3'h6)) u_weekday_digit (
		.pclk(pclk), .ce(ce),
		.load(wr_wh && hi_lane),
		.load_val(pwdata[`WEEKDAY_DIGIT_MSB:`WEEKDAY_DIGIT_LSB]),
		.inc(day_end), .wrap_at(3'h6),
		.value(weekday_digit), .carry()
	);

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	// pointer, unlock and run bits written by software
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			value_view_pointer_q <= `PTR_RESET;
			clock_write_unlock_q <= 1'b0;
			run_q                <= 1'b0;
		end
		else if (ce && wr_now && hit_ctrl)
		begin
			if (lo_lane)
				value_view_pointer_q <= pwdata[`CTRL_PTR_MSB:`CTRL_PTR_LSB];
			if (hi_lane)
			begin
				clock_write_unlock_q <= pwdata[`CTRL_UNLOCK_BIT];
				run_q                <= pwdata[`CTRL_ENABLE_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	reg [31:0] rd_mux;
	always @*
	begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl)
		begin
			rd_mux[`CTRL_PTR_MSB:`CTRL_PTR_LSB] = value_view_pointer_q;
			rd_mux[`CTRL_UNLOCK_BIT]           = clock_write_unlock_q;
			rd_mux[`CTRL_ENABLE_BIT]           = run_q;
		end
		else if (hit_val && view_wh)
		begin
			rd_mux[`WEEKDAY_DIGIT_MSB:`WEEKDAY_DIGIT_LSB]     = weekday_digit;
			rd_mux[`HR_TEN_MSB:`HR_TEN_LSB] = hr_ten;
			rd_mux[`HR_ONE_MSB:`HR_ONE_LSB] = hr_one;
		end
		else if (hit_val && view_ms)
		begin
			rd_mux[`MIN_TEN_MSB:`MIN_TEN_LSB] = min_ten;
			rd_mux[`MIN_ONE_MSB:`MIN_ONE_LSB] = min_one;
			rd_mux[`SEC_TEN_MSB:`SEC_TEN_LSB] = sec_ten;
			rd_mux[`SEC_ONE_MSB:`SEC_ONE_LSB] = sec_one;
		end
	end

	// ----------------------------------------------------------------
	// apb answer: ready in the first access cycle
	// ----------------------------------------------------------------
	// registered so every output comes from a flip-flop
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata      <= 32'h0000_0000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			second_tick <= 1'b0;
		end
		else if (ce)
		begin
			second_tick <= tick;
			pready      <= setup;
			pslverr     <= setup && !(hit_ctrl || hit_val);
			if (setup && !pwrite)
				prdata <= rd_mux;
		end
	end

endmodule // rtc_time_value_window

// ===== rtl/rtc_window_map.vh
// Purpose: constants of the real-time clock time value window
// Assumes: apb register bus, 32-bit words, pclk at 40 MHz
// Notes: time digits are packed bcd; unused bits read as zero
// Function
// - pointer 01 selects weekday and hours view
// - pointer 00 selects minutes and seconds view
// - weekday in bits 10:8, range 0-6
// - hour tens in bits 5:4, range 0-2
// - hour ones in bits 3:0, range 0-9
// - weekday/hours write needs unlock bit set
// - minute tens in bits 14:12, range 0-5
// - minute ones in bits 11:8, range 0-9
// - second tens in bits 6:4, range 0-5
// - second ones in bits 3:0, range 0-9
`ifndef RTC_WINDOW_MAP_VH
`define RTC_WINDOW_MAP_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CTRL_ADDR        12'h000
`define VALUE_ADDR       12'h004

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_PTR_LSB     0
`define CTRL_PTR_MSB     1
`define CTRL_UNLOCK_BIT  8
`define CTRL_ENABLE_BIT  15
`define PTR_RESET        2'h0
`define PTR_MIN_SEC      2'h0
`define PTR_WEEKDAY_DIGIT_HOUR    2'h1

// ----------------------------------------------------------------
// digit fields of the two views
// ----------------------------------------------------------------
`define WEEKDAY_DIGIT_MSB         10
`define WEEKDAY_DIGIT_LSB         8
`define HR_TEN_MSB       5
`define HR_TEN_LSB       4
`define HR_ONE_MSB       3
`define HR_ONE_LSB       0
`define MIN_TEN_MSB      14
`define MIN_TEN_LSB      12
`define MIN_ONE_MSB      11
`define MIN_ONE_LSB      8
`define SEC_TEN_MSB      6
`define SEC_TEN_LSB      4
`define SEC_ONE_MSB      3
`define SEC_ONE_LSB      0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ           40000000
`define TICK_PERIOD_S    1
`define TICK_CYCLES      (`CLK_HZ * `TICK_PERIOD_S)

`endif

// ===== verification/rtc_time_value_window_tb.sv
// Purpose: directed regression of the time value window
// Assumes: short tick of 8 cycles, ce and all strobes held on outside the lane and freeze tests
// Notes: time digits are written before they are read
`timescale 1ns/1ps
`include "rtc_window_map.vh"
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin n_errors++; \
	$display("unexpected at %0t got %h exp %h", $time, g, x); end end
module rtc_time_value_window_tb;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h0;
	reg  [31:0] pwdata = 32'h0;
	reg         ce = 1'b1;           // clock enable, dropped to prove the freeze
	reg  [3:0]  pstrb = 4'hf;        // byte lanes, narrowed for lane tests
	reg  [31:0] r;
	reg         e;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire        second_tick;
	integer     n_errors = 0;
	integer     compares = 0;
	rtc_time_value_window #(.TICK_CYCLES(32'd8)) rtc_time_value_window_i (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .second_tick(second_tick));
	initial forever #12.5 pclk = ~pclk;
	// one apb transfer; request held until ready is seen
	task xfer(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input [11:0] a, input [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rd(input [11:0] a, input [31:0] x);
		xfer(1'b0, a, 32'h0);
		`CHK(r, x)
	endtask
	task test_done;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// watchdog far beyond the few hundred cycles the tests need
	initial
	begin
		#100000;
		n_errors++;
		test_done;
	end
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		wr(`CTRL_ADDR, 32'h0);
		wr(`VALUE_ADDR, 32'hffff);
		rd(`VALUE_ADDR, 32'h5959);
		wr(`VALUE_ADDR, 32'h4208);
		rd(`VALUE_ADDR, 32'h4208);
		$display("test 1 end");
		wr(`CTRL_ADDR, 32'h0101);
		wr(`VALUE_ADDR, 32'h0623);
		rd(`VALUE_ADDR, 32'h0623);
		wr(`CTRL_ADDR, 32'h0001);
		wr(`VALUE_ADDR, 32'h0000);
		rd(`VALUE_ADDR, 32'h0623);
		wr(`CTRL_ADDR, 32'h0000);
		rd(`VALUE_ADDR, 32'h4208);
		$display("test 2 end");
		wr(`CTRL_ADDR, 32'h0002);
		rd(`VALUE_ADDR, 32'h0);
		xfer(1'b0, 12'h008, 32'h0);
		`CHK(e, 1'b1)
		$display("test 3 end");
		wr(`CTRL_ADDR, 32'h0000);
		wr(`VALUE_ADDR, 32'h5959);
		wr(`CTRL_ADDR, 32'h8000);
		while (second_tick !== 1'b1) @(posedge pclk);
		wr(`CTRL_ADDR, 32'h0001);
		rd(`VALUE_ADDR, 32'h0);
		wr(`CTRL_ADDR, 32'h0000);
		rd(`VALUE_ADDR, 32'h0);
		$display("test 4 end");
		// byte lanes: low lane loads seconds only, high lane minutes only
		pstrb <= 4'h1;
		wr(`VALUE_ADDR, 32'h1234);
		rd(`VALUE_ADDR, 32'h0034);
		pstrb <= 4'h2;
		wr(`VALUE_ADDR, 32'h5100);
		rd(`VALUE_ADDR, 32'h5134);
		pstrb <= 4'hf;
		$display("test 5 end");
		// run the clock with ce low: forty frozen cycles would be five ticks
		wr(`CTRL_ADDR, 32'h8000);
		ce <= 1'b0;
		repeat (40) @(posedge pclk);
		ce <= 1'b1;
		wr(`CTRL_ADDR, 32'h0000);
		rd(`VALUE_ADDR, 32'h5134);
		$display("test 6 end");
		// reset with pointer and unlock set clears control but keeps the digits
		wr(`CTRL_ADDR, 32'h0101);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`CTRL_ADDR, 32'h0);
		rd(`VALUE_ADDR, 32'h5134);
		$display("test 7 end");
		test_done;
	end
endmodule // rtc_time_value_window_tb
bind rtc_time_value_window rtc_window_sva rtc_window_sva_i (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .second_tick(second_tick));

// ===== verification/rtc_window_sva.sv
// Purpose: bus and digit field checks on the time window
// Assumes: ce high, pointer tracked from control writes
// Notes: value reads before any time write are unknown
`timescale 1ns/1ps
module rtc_window_sva (
	input wire        pclk,
	input wire        presetn,
	input wire        ce,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0]  pstrb,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        second_tick
);
	reg  [1:0] ptr_q;                                // pointer as last written
	wire       ok_rd = pready && !pslverr && !pwrite; // read answered
	wire       rd    = ok_rd && paddr == 12'h004;     // value read answered
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// follow control writes so each read knows its view
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			ptr_q <= 2'h0;
		else if (psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[0])
			ptr_q <= pwdata[1:0];
	rdy_after_setup_a: assert property (psel && !penable && ce |=> pready)
		else $error("no answer after setup");
	rdy_one_cycle_a: assert property (pready && ce |=> !pready) else $error("ready held");
	err_with_rdy_a: assert property (pslverr |-> pready) else $error("lone error");
	rdy_in_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
	upper_zero_a: assert property (ok_rd |-> prdata[31:16] == 16'h0) else $error("upper bits set");
	min_sec_fields_a: assert property (rd && ptr_q == 2'h0 |-> !prdata[15] && !prdata[7]
		&& prdata[14:12] <= 3'h5 && prdata[11:8] <= 4'h9 && prdata[6:4] <= 3'h5 && prdata[3:0] <= 4'h9)
		else $error("minute or second digit out of range");
	weekday_digit_hour_fields_a: assert property (rd && ptr_q == 2'h1 |-> prdata[15:11] == 5'h0
		&& prdata[10:8] <= 3'h6 && prdata[7:6] == 2'h0 && prdata[5:4] <= 2'h2 && prdata[3:0] <= 4'h9)
		else $error("weekday or hour digit out of range");
	dead_view_zero_a: assert property (rd && ptr_q[1] |-> prdata == 32'h0) else $error("dead view");
	tick_pulse_a: assert property (second_tick |=> !second_tick) else $error("tick held");
	cover property (rd && ptr_q == 2'h1);
	cover property (pslverr);
	cover property (second_tick);
endmodule // rtc_window_sva
